// file: rtl/rx_release_consts.svh
// Constants for the received-payload release timer
`ifndef RX_RELEASE_CONSTS_SVH
`define RX_RELEASE_CONSTS_SVH
`define CLK_HZ 20000000
`define TICK_MS_NUM 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS_NUM)
`define DEFAULT_HOLD_MS 16'h03e8
`define ADDR_CTRL 12'h000
`define ADDR_RX_DELAY 12'h004
`define ADDR_CTS_DELAY 12'h008
`define ADDR_STATUS 12'h00c
`define CTRL_BIT_ENABLE 0
`define CTRL_BIT_CTS_KEY 1
`define STATUS_BIT_HOLDING 0
`define STATUS_BIT_OUT_VALID 1
`define STATUS_BIT_IN_READY 2
`define SETTING_W 8
`endif

// file: rtl/rx_release_pkg.sv
// Types for the received-payload release timer
package rx_release_pkg;
   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_DEFAULT_SECOND,
      MODE_RX_DELAY,
      MODE_CTS_KEY
   } hold_mode_t;
endpackage

// file: rtl/skid_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module skid_buffer #(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic [1:0] count;
   } buf_t;

   buf_t r;
   buf_t next_r;
   logic push;
   logic pop;

   // Refuse an empty word at elaboration, before any logic is built
   if (WIDTH < 1) begin : g_bad_width
      $error("skid_buffer WIDTH must be positive");
   end

   // Entry 0 is the head; read data come from a register
   assign in_ready = (r.count != 2'd2);
   assign out_valid = (r.count != 2'd0);
   assign out_data = r.mem[0];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Shift on pop so the head always stays in entry 0
   always_comb begin
      next_r = r;
      if (pop) begin
         next_r.mem[0] = r.mem[1];
      end
      if (push) begin
         if (pop) begin
            next_r.mem[r.count - 2'd1] = in_data;
         end else begin
            next_r.mem[r.count[0]] = in_data;
         end
      end
      next_r.count = r.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule
`default_nettype wire

// file: rtl/rx_payload_release_timer.sv
// Release timer that holds received radio payload before serial output
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rx_release_consts.svh"

module rx_payload_release_timer #(
   parameter int DATA_W = 8,
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic rts,
   output logic out_valid,
   input wire logic out_ready,
   output logic [DATA_W-1:0] out_data
);
   typedef struct packed {
      logic enable;
      logic cts_key;
      logic [`SETTING_W-1:0] rx_delay_ms;
      logic [`SETTING_W-1:0] cts_delay_ms;
      logic holding;
      logic released;
      logic [15:0] ms_left;
      logic [31:0] tick_cnt;
      logic [31:0] rdata;
      logic [DATA_W-1:0] hold_data;
      logic hold_full;
   } state_t;

   state_t r;
   state_t next_r;
   logic buf_in_valid;
   logic buf_in_ready;
   logic setup_access;
   logic wr;
   logic addr_ok;
   logic tick;
   logic expired;
   logic cancel;
   rx_release_pkg::hold_mode_t mode;

   // Refuse parameters at elaboration; a word must fit one bus read
   if (DATA_W < 1 || DATA_W > 32 || TICK_CYCLES < 1) begin : g_bad_params
      $error("rx_payload_release_timer: unsupported parameters");
   end

   // Known register offsets only
   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == `ADDR_CTRL) || (a == `ADDR_RX_DELAY) ||
         (a == `ADDR_CTS_DELAY) || (a == `ADDR_STATUS);
   endfunction

   // Pick the hold length mode by rank
   function automatic rx_release_pkg::hold_mode_t pick_mode(input logic en,
         input logic key, input logic [`SETTING_W-1:0] rxd);
      if (key) begin
         pick_mode = rx_release_pkg::MODE_CTS_KEY;
      end else if (rxd != '0) begin
         pick_mode = rx_release_pkg::MODE_RX_DELAY;
      end else if (en) begin
         pick_mode = rx_release_pkg::MODE_DEFAULT_SECOND;
      end else begin
         pick_mode = rx_release_pkg::MODE_NONE;
      end
   endfunction

   // APB decode, single-cycle answer
   assign setup_access = psel && penable;
   assign addr_ok = addr_mapped(paddr);
   assign wr = setup_access && pwrite && addr_ok;
   assign pready = 1'b1;
   assign pslverr = setup_access && !addr_ok;
   assign prdata = r.rdata;

   assign mode = pick_mode(r.enable, r.cts_key, r.rx_delay_ms);
   assign tick = (r.tick_cnt == 32'(TICK_CYCLES - 1));
   assign expired = r.holding && tick && (r.ms_left <= 16'h0001);
   // Rts only cancels in modes where it may end the wait
   assign cancel = r.holding && rts &&
      ((mode == rx_release_pkg::MODE_CTS_KEY) || r.enable);
   assign rx_ready = !r.hold_full;
   assign buf_in_valid = r.hold_full && r.released;

   // Read data are registered at the end of the setup phase, so prdata is ready in the access phase
   always_comb begin
      next_r = r;
      next_r.rdata = r.rdata;
      if (wr) begin
         case (paddr)
            `ADDR_CTRL: begin
               next_r.enable = pwdata[`CTRL_BIT_ENABLE];
               next_r.cts_key = pwdata[`CTRL_BIT_CTS_KEY];
            end
            `ADDR_RX_DELAY: begin
               next_r.rx_delay_ms = pwdata[`SETTING_W-1:0];
            end
            `ADDR_CTS_DELAY: begin
               next_r.cts_delay_ms = pwdata[`SETTING_W-1:0];
            end
            default: begin
               next_r.rdata = r.rdata;
            end
         endcase
      end
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `ADDR_CTRL: begin
               next_r.rdata = 32'h0000_0000;
               next_r.rdata[`CTRL_BIT_ENABLE] = r.enable;
               next_r.rdata[`CTRL_BIT_CTS_KEY] = r.cts_key;
            end
            `ADDR_RX_DELAY: begin
               next_r.rdata = {24'h000000, r.rx_delay_ms};
            end
            `ADDR_CTS_DELAY: begin
               next_r.rdata = {24'h000000, r.cts_delay_ms};
            end
            `ADDR_STATUS: begin
               next_r.rdata = 32'h0000_0000;
               next_r.rdata[`STATUS_BIT_HOLDING] = r.holding;
               next_r.rdata[`STATUS_BIT_OUT_VALID] = out_valid;
               next_r.rdata[`STATUS_BIT_IN_READY] = rx_ready;
            end
            default: begin
               next_r.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Millisecond tick runs only while a hold is pending
      if (r.holding) begin
         next_r.tick_cnt = tick ? 32'h0000_0000 : r.tick_cnt + 32'h0000_0001;
         if (tick) begin
            next_r.ms_left = r.ms_left - 16'h0001;
         end
      end else begin
         next_r.tick_cnt = 32'h0000_0000;
      end
      if (expired || cancel) begin
         next_r.holding = 1'b0;
         next_r.released = 1'b1;
      end

      // Hand the released word to the output buffer; stalls keep it here
      if (buf_in_valid && buf_in_ready) begin
         next_r.hold_full = 1'b0;
         next_r.released = 1'b0;
      end

      // Capture a new payload and start its hold
      if (rx_valid && !r.hold_full) begin
         next_r.hold_data = rx_data;
         next_r.hold_full = 1'b1;
         next_r.tick_cnt = 32'h0000_0000;
         case (mode)
            rx_release_pkg::MODE_CTS_KEY: begin
               next_r.ms_left = {8'h00, r.cts_delay_ms};
            end
            rx_release_pkg::MODE_RX_DELAY: begin
               next_r.ms_left = {8'h00, r.rx_delay_ms};
            end
            rx_release_pkg::MODE_DEFAULT_SECOND: begin
               next_r.ms_left = `DEFAULT_HOLD_MS;
            end
            default: begin
               next_r.ms_left = 16'h0000;
            end
         endcase
         // A zero length hold passes straight through
         if ((mode == rx_release_pkg::MODE_NONE) ||
               ((mode == rx_release_pkg::MODE_CTS_KEY) && (r.cts_delay_ms == '0))) begin
            next_r.holding = 1'b0;
            next_r.released = 1'b1;
         end else begin
            next_r.holding = 1'b1;
            next_r.released = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Output buffer so a stalled receiver loses no word
   skid_buffer #(
      .WIDTH(DATA_W)
   ) u_out_buf (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(r.hold_data),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );
endmodule
`default_nettype wire

// file: test/rx_release_host.sv
// Host terminal model on the serial receive side
`timescale 1ns/10ps
`default_nettype none
module rx_release_host (
   input wire logic stall,
   input wire logic rts_req,
   output logic out_ready,
   output logic rts
);
   // Early delivery only when the bench asks for it
   assign rts = rts_req;
   // A stalling host simply refuses words
   assign out_ready = !stall;
endmodule
`default_nettype wire

// file: test/rx_payload_release_timer_assertions.sv
// Port checks for the release timer
`timescale 1ns/10ps
`default_nettype none
module release_checker #(
   parameter int DATA_W = 8,
   parameter int TICK_CYCLES = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic rts,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [DATA_W-1:0] out_data
);
   logic en, key, rxz, ok_a;
   assign ok_a = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c};
   // Mode shadow, so a hold can be judged without the bodies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en <= 1'b0;
         key <= 1'b0;
         rxz <= 1'b1;
      end else if (psel && penable && pwrite && paddr == 12'h000) begin
         en <= pwdata[0];
         key <= pwdata[1];
      end else if (psel && penable && pwrite && paddr == 12'h004) begin
         rxz <= pwdata[7:0] == 8'h00;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_fresh;
      rx_valid && rx_ready && !out_valid;
   endsequence
   sequence s_held_rts;
      !rx_ready && !out_valid && rts;
   endsequence
   a_bad_addr: assert property (psel && penable && !ok_a |-> pslverr)
      else $error("unmapped access not flagged");
   a_bad_read: assert property (psel && !penable && !pwrite && !ok_a |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_one_second: assert property (
      s_fresh ##0 (en && !key && rxz) ##1 (!rts)[*8] |-> !out_valid)
      else $error("early release");
   a_rts_cut: assert property (s_held_rts ##0 en |-> ##[1:4] out_valid)
      else $error("rts did not release");
   a_key_cut: assert property (s_held_rts ##0 key |-> ##[1:4] out_valid)
      else $error("rts did not release");
   a_no_hold: assert property (
      s_fresh ##0 (!en && !key && rxz) |-> ##[1:3] out_valid)
      else $error("unheld word late");
   a_slot_busy: assert property (rx_valid && rx_ready |=> !rx_ready)
      else $error("second word taken");
   a_out_stand: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output word dropped");
endmodule
bind rx_payload_release_timer release_checker #(.DATA_W(DATA_W), .TICK_CYCLES(TICK_CYCLES)) c_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .rx_valid(rx_valid),
   .rx_ready(rx_ready), .rts(rts), .out_valid(out_valid), .out_ready(out_ready),
   .out_data(out_data));
`default_nettype wire

// file: test/rx_payload_release_timer_bench.sv
// Self-checking bench for the release timer
`timescale 1ns/10ps
`default_nettype none
module rx_payload_release_timer_bench;
   localparam int T = 4;
   localparam int HOP = 3; // hop_period in ms
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic rx_valid, rx_ready, rts, out_valid, out_ready, stall, rts_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] rx_data, out_data;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;
   rx_payload_release_timer #(.DATA_W(8), .TICK_CYCLES(T)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rts(rts),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
   rx_release_host host (.stall(stall), .rts_req(rts_req), .out_ready(out_ready), .rts(rts));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard; the longest hold is about 4000 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("ERROR %s exp %h got %h", s, x, g);
      end
   endtask
   // Cycle counts are judged against a window, and the count is printed when it falls outside
   task automatic chk_cycles(input string s, input int lo, input int hi, input int n);
      total_checks++;
      if (n < lo || n > hi) begin
         err_total++;
         $display("ERROR %s exp %0d to %0d got %0d", s, lo, hi, n);
      end
   endtask
   // One APB transfer, held until pready; reads are compared
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      if (!w) chk("prdata", d, prdata);
      chk("pslverr", e, pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic push(input logic [7:0] d);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= d;
      do @(posedge pclk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
   endtask
   // Cycles from capture to delivery must land in lo..hi
   task automatic hold(input logic [7:0] d, input int lo, input int hi, input int rts_at);
      int n;
      n = 0;
      push(d);
      while (out_valid !== 1'b1) begin
         @(posedge pclk);
         n++;
         if (n == rts_at) rts_req <= 1'b1;
      end
      rts_req <= 1'b0;
      chk_cycles("hold", lo, hi, n);
      chk("out_data", d, out_data);
   endtask
   task automatic t_regs;
      apb(1, 12'h004, 32'hffff_ffff, 0);
      apb(0, 12'h004, 32'h0000_00ff, 0);
      apb(0, 12'h010, 32'h0, 1);
      apb(1, 12'h004, 32'h0, 0);
   endtask
   task automatic t_modes;
      apb(1, 12'h000, 32'h1, 0);
      hold(8'ha5, 1000 * T, 1000 * T + 3, 0);
      hold(8'h5a, 11, 14, 10);
      apb(1, 12'h004, 2 * HOP, 0);
      hold(8'h3c, 2 * HOP * T, 2 * HOP * T + 3, 0);
      apb(1, 12'h008, 32'h5, 0);
      apb(0, 12'h008, 32'h0000_0005, 0);
      apb(1, 12'h000, 32'h3, 0);
      apb(0, 12'h000, 32'h0000_0003, 0);
      hold(8'hc3, 5 * T, 5 * T + 3, 0);
      apb(1, 12'h000, 32'h2, 0);
      hold(8'h99, 8, 12, 7);
   endtask
   // Stalled host: buffer plus hold slot take three words, in order
   task automatic t_fill;
      int k;
      apb(1, 12'h000, 32'h0, 0);
      apb(1, 12'h004, 32'h0, 0);
      stall <= 1'b1;
      for (k = 1; k <= 3; k++) push(k);
      repeat (3) @(posedge pclk);
      chk("rx_ready", 0, rx_ready);
      // Status while stalled: nothing holding, output waiting, slot full
      apb(0, 12'h00c, 32'h0000_0002, 0);
      stall <= 1'b0;
      for (k = 1; k <= 3; k++) begin
         do @(posedge pclk); while (out_valid !== 1'b1);
         chk("out_data", k, out_data);
      end
   endtask
   // Reset in mid-run drops a held word and clears the settings
   task automatic t_reset;
      apb(1, 12'h000, 32'h0000_0001, 0);
      push(8'h77);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("rx_ready", 1, rx_ready);
      chk("out_valid", 0, out_valid);
      chk("prdata", 0, prdata);
      presetn <= 1'b1;
      apb(0, 12'h000, 32'h0000_0000, 0);
      repeat (4) @(posedge pclk);
      chk("out_valid", 0, out_valid);
   endtask
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, rx_valid, stall, rts_req} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      rx_data = 8'h00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_modes();
      t_fill();
      t_reset();
      stop_test();
   end
endmodule
`default_nettype wire
